// ===== inc/tmp_pkg.sv
// Constants, register map and types of the trapezoid motion profiler
package tmp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / TICK_HZ;
  localparam int MILLI = 1000;
  localparam int VMAX = 100000;
  localparam int RAMP_MAX_S = 300;
  localparam logic [31:0] ACC_MIN =
    32'((VMAX + RAMP_MAX_S - 1) / RAMP_MAX_S);
  localparam logic [37:0] STEP_THR = 38'h174876e800;
  localparam logic [27:0] VMIN_M = 28'h00003e8;
  localparam logic [23:0] BRK_K = 24'h1e8480;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_DEC = 8'h08;
  localparam logic [7:0] OFF_SPD = 8'h0c;
  localparam logic [7:0] OFF_BLS = 8'h10;
  localparam logic [7:0] OFF_BLD = 8'h14;
  localparam logic [7:0] OFF_TGT = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1c;
  localparam logic [7:0] OFF_POS = 8'h20;
  localparam logic [7:0] OFF_VEL = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  localparam logic [7:0] OFF_IST = 8'h2c;
  localparam logic [7:0] OFF_IMSK = 8'h30;
  localparam logic [7:0] OFF_LIML = 8'h34;
  localparam logic [7:0] OFF_LIMR = 8'h38;
  localparam int C_RAMP = 0;
  localparam int C_BLEN = 1;
  localparam int C_REV = 2;
  localparam int K_FORCE = 0;
  localparam int K_STOP = 1;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [31:0] ACC_RST = 32'h00000fa0;
  localparam logic [31:0] DEC_RST = 32'h00001f40;
  localparam logic [16:0] SPD_RST = 17'h003e8;
  localparam logic [16:0] BLS_RST = 17'h001f4;
  localparam logic [31:0] BLD_RST = 32'h00000064;
  localparam int NEV = 3;
  localparam int E_DONE = 0;
  localparam int E_BAD = 1;
  localparam int E_BLD = 2;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_BL_OUT, S_BL_BACK} tmp_st_t;
endpackage

// ===== rtl/tmp_top.sv
// Trapezoid motion profiler with backlash approach and reversal
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - While below commanded speed, speed rises by the acceleration rate.
// RL2 - At commanded speed the ramp ends and speed is held.
// RL3 - Near target speed falls at deceleration rate, stopping on target.
// RL4 - Short moves go straight from speeding up to slowing down.
// RL5 - Acceleration and deceleration are separate; ramping can be disabled.
// RL6 - Ramp settings slower than five minutes flag an error and clamp.
// RL7 - Wrong approach side: overshoot by backlash distance, then return.
// RL8 - Overshoot and return run at the separate backlash speed.
// RL9 - Positive distance approaches from left, negative from right.
// RL10 - Status shows a flag while backlash motion runs.
// RL11 - Forced backlash moves by the distance and comes back.
// RL12 - Forced backlash while moving first makes a smooth stop.
// RL13 - Host issues forced backlash only with backlash enabled.
// RL14 - Rising coordinate means rightward motion by default.
// RL15 - Reversal negates the coordinate and swaps physical directions; DIR stays 1 for a rising coordinate either way.
// RL16 - Limit settings are untouched by the reversal setting.
// RL17 - Ramping is enabled after reset.
// RL18 - Without ramping, speed jumps to command and stops dead.
module tmp_top #(
  parameter int TICK_CYC = tmp_pkg::TICK_CYC_DEF
) (
  input  wire logic                  CLK,   // Clock, 100 MHz
  input  wire logic                  RESET, // Synchronous reset
  input  wire logic [tmp_pkg::AW-1:0] ADDR,  // Register byte address
  input  wire logic [tmp_pkg::DW-1:0] WDATA, // Write data
  input  wire logic                  WR,    // Write strobe
  input  wire logic                  RD,    // Read strobe
  output logic      [tmp_pkg::DW-1:0] RDATA, // Read data, next cycle
  output logic                       STEP,  // One-cycle step pulse
  output logic                       DIR,   // Direction, 1 = right
  output logic                       IRQ    // Interrupt level
);
  import tmp_pkg::*;

  logic [2:0]         ctrl_reg;
  logic [31:0]        acc_reg;
  logic [31:0]        dec_reg;
  logic [16:0]        spd_reg;
  logic [16:0]        bls_reg;
  logic signed [31:0] bld_reg;
  logic [31:0]        liml_reg;
  logic [31:0]        limr_reg;
  logic [NEV-1:0]     imsk_reg;
  logic [NEV-1:0]     ist_reg;
  tmp_st_t            st_reg;
  logic signed [31:0] pos_reg;
  logic signed [31:0] goal_reg;
  logic signed [31:0] fin_reg;
  logic [27:0]        vel_reg;
  logic [37:0]        ph_reg;
  logic               dir_reg;
  logic               stop_reg;
  logic               force_reg;
  logic               blp_reg;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic [NEV-1:0]     ev;

  wire wr_ctrl = WR && ADDR == OFF_CTRL;
  wire wr_rate = WR && (ADDR == OFF_ACC || ADDR == OFF_DEC);
  wire bad_rate = wr_rate && WDATA < ACC_MIN;
  wire start_ev = WR && ADDR == OFF_TGT;
  wire force_ev = WR && ADDR == OFF_CMD && WDATA[K_FORCE];
  wire sstop_ev = WR && ADDR == OFF_CMD && WDATA[K_STOP];
  wire rev_tgl = wr_ctrl && WDATA[C_REV] != ctrl_reg[C_REV];
  wire ramp_en = ctrl_reg[C_RAMP];
  wire bl_en = ctrl_reg[C_BLEN];
  wire moving = st_reg != S_IDLE;
  wire bl_flag = st_reg == S_BL_OUT || st_reg == S_BL_BACK;
  wire signed [31:0] tgt_w = $signed(WDATA);

  // Speeds kept in milli-steps per second, so each 1 ms tick adds
  // exactly the rate in steps per second squared
  wire [27:0] vsp_m = 28'(spd_reg * 17'(MILLI));
  wire [27:0] vbl_m = 28'(bls_reg * 17'(MILLI));
  wire [27:0] vc_m = bl_flag ? vbl_m : vsp_m; // RL8
  wire at_goal = pos_reg == goal_reg;
  wire [31:0] rem = 32'(pos_reg < goal_reg ? goal_reg - pos_reg
                                            : pos_reg - goal_reg);
  wire [87:0] v_sq = 88'(vel_reg) * 88'(vel_reg);
  // Brake point follows the tick length so short ticks still stop on target
  wire [95:0] brk_rhs = 96'(dec_reg) * 96'(rem) * 96'(BRK_K) *
                        96'(TICK_CYC_DEF / TICK_CYC);
  wire brake = ramp_en && v_sq >= brk_rhs;
  wire [32:0] v_up = 33'(vel_reg) + 33'(acc_reg);
  wire [32:0] v_dn = 33'(vel_reg) - 33'(dec_reg);
  wire dn_neg = v_dn[32];
  wire [37:0] ph_sum = ph_reg + 38'(vel_reg);
  wire done = moving && (at_goal || (stop_reg && vel_reg == 28'h0));
  // Overshoot needed when natural side differs from the chosen one
  wire need_bl = bl_en && ((bld_reg > 0 && tgt_w < pos_reg) ||
                           (bld_reg < 0 && tgt_w > pos_reg)); // RL7 RL9

  // Ramp update rate
  always_ff @(posedge CLK) begin
    if (RESET || tick_cnt == 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 32'(TICK_CYC - 1);
    end
  end

  // Settings; limit words ignore reversal on purpose
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= CTRL_RST; // RL17
      acc_reg  <= ACC_RST;
      dec_reg  <= DEC_RST;
      spd_reg  <= SPD_RST;
      bls_reg  <= BLS_RST;
      bld_reg  <= BLD_RST;
      liml_reg <= 32'h0;
      limr_reg <= 32'h0;
      imsk_reg <= '0;
    end else if (WR) begin
      case (ADDR)
        OFF_CTRL: ctrl_reg <= WDATA[2:0]; // RL5
        OFF_ACC:  acc_reg <= bad_rate ? ACC_MIN : WDATA; // RL5 RL6
        OFF_DEC:  dec_reg <= bad_rate ? ACC_MIN : WDATA; // RL5 RL6
        OFF_SPD:  spd_reg <= WDATA > VMAX ? 17'(VMAX) : WDATA[16:0];
        OFF_BLS:  bls_reg <= WDATA > VMAX ? 17'(VMAX) : WDATA[16:0];
        OFF_BLD:  bld_reg <= tgt_w;
        OFF_LIML: liml_reg <= WDATA; // RL16
        OFF_LIMR: limr_reg <= WDATA; // RL16
        OFF_IMSK: imsk_reg <= WDATA[NEV-1:0];
        default: ;
      endcase
    end
  end

  // Motion sequencer, step generator and coordinate
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_reg    <= S_IDLE;
      pos_reg   <= '0;
      goal_reg  <= '0;
      fin_reg   <= '0;
      vel_reg   <= 28'h0;
      ph_reg    <= 38'h0;
      dir_reg   <= 1'b1;
      stop_reg  <= 1'b0;
      force_reg <= 1'b0;
      blp_reg   <= 1'b0;
      STEP      <= 1'b0;
    end else if (rev_tgl) begin
      pos_reg  <= -pos_reg; // RL15
      goal_reg <= -goal_reg;
      fin_reg  <= -fin_reg;
      dir_reg  <= ~dir_reg;
      STEP     <= 1'b0;
    end else begin
      STEP <= 1'b0;
      case (st_reg)
        S_IDLE: begin
          if (force_ev && bl_en) begin
            fin_reg  <= pos_reg; // RL11
            goal_reg <= pos_reg - bld_reg;
            dir_reg  <= bld_reg < 0;
            vel_reg  <= ramp_en ? 28'h0 : vbl_m;
            ph_reg   <= 38'h0;
            st_reg   <= S_BL_OUT;
          end else if (start_ev) begin
            fin_reg  <= tgt_w;
            goal_reg <= tgt_w;
            dir_reg  <= tgt_w > pos_reg; // RL14
            blp_reg  <= need_bl;
            vel_reg  <= ramp_en ? 28'h0 : vsp_m; // RL18
            ph_reg   <= 38'h0;
            st_reg   <= S_RUN;
          end
        end
        S_RUN, S_BL_OUT, S_BL_BACK: begin
          if (force_ev && bl_en) begin
            stop_reg  <= 1'b1; // RL12
            force_reg <= 1'b1;
          end else if (sstop_ev) begin
            stop_reg <= 1'b1;
          end
          if (done) begin
            vel_reg  <= ramp_en ? 28'h0 : vbl_m;
            ph_reg   <= 38'h0;
            stop_reg <= 1'b0;
            if (force_reg) begin
              force_reg <= 1'b0;
              fin_reg   <= pos_reg; // RL11
              goal_reg  <= pos_reg - bld_reg;
              dir_reg   <= bld_reg < 0;
              st_reg    <= S_BL_OUT;
            end else if (stop_reg) begin
              st_reg <= S_IDLE;
            end else if (st_reg == S_RUN && blp_reg) begin
              goal_reg <= fin_reg - bld_reg; // RL7
              dir_reg  <= bld_reg < 0;
              blp_reg  <= 1'b0;
              st_reg   <= S_BL_OUT;
            end else if (st_reg == S_BL_OUT) begin
              goal_reg <= fin_reg; // RL7 RL11
              dir_reg  <= bld_reg > 0; // RL9
              st_reg   <= S_BL_BACK;
            end else begin
              st_reg <= S_IDLE;
            end
          end else begin
            if (ph_sum >= STEP_THR) begin
              ph_reg  <= ph_sum - STEP_THR;
              pos_reg <= dir_reg ? pos_reg + 1 : pos_reg - 1;
              STEP    <= 1'b1;
            end else begin
              ph_reg <= ph_sum;
            end
            if (!ramp_en) begin
              vel_reg <= stop_reg ? 28'h0 : vc_m; // RL18
            end else if (tick) begin
              if (stop_reg) begin
                vel_reg <= dn_neg ? 28'h0 : v_dn[27:0]; // RL12
              end else if (brake) begin
                // Crawl floor so rounding cannot stall short of target
                vel_reg <= dn_neg || v_dn[27:0] < VMIN_M ? VMIN_M
                                                        : v_dn[27:0]; // RL3 RL4
              end else if (v_up < 33'(vc_m)) begin
                vel_reg <= v_up[27:0]; // RL1
              end else begin
                vel_reg <= vc_m; // RL2
              end
            end
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  assign ev[E_DONE] = done && !force_reg &&
                      (stop_reg || st_reg == S_BL_BACK ||
                       (st_reg == S_RUN && !blp_reg));
  assign ev[E_BAD] = bad_rate; // RL6
  assign ev[E_BLD] = done && st_reg == S_BL_BACK && !force_reg;

  // Sticky events; a new event beats the clearing read
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ist_reg <= '0;
    end else if (RD && ADDR == OFF_IST) begin
      ist_reg <= ev;
    end else begin
      ist_reg <= ist_reg | ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
      DIR <= 1'b1;
    end else begin
      IRQ <= |(ist_reg & imsk_reg);
      DIR <= dir_reg; // RL14
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !RD) begin
      RDATA <= 32'h0;
    end else begin
      case (ADDR)
        OFF_CTRL: RDATA <= {29'h0, ctrl_reg};
        OFF_ACC:  RDATA <= acc_reg;
        OFF_DEC:  RDATA <= dec_reg;
        OFF_SPD:  RDATA <= {15'h0, spd_reg};
        OFF_BLS:  RDATA <= {15'h0, bls_reg};
        OFF_BLD:  RDATA <= bld_reg;
        OFF_TGT:  RDATA <= fin_reg;
        OFF_POS:  RDATA <= pos_reg;
        OFF_VEL:  RDATA <= {4'h0, vel_reg};
        OFF_STAT: RDATA <= {30'h0, bl_flag, moving}; // RL10
        OFF_IST:  RDATA <= {29'h0, ist_reg};
        OFF_IMSK: RDATA <= {29'h0, imsk_reg};
        OFF_LIML: RDATA <= liml_reg;
        OFF_LIMR: RDATA <= limr_reg;
        default:  RDATA <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  wire run_ok = moving && !done && !rev_tgl && tick && ramp_en;
  property p_ramp_up;
    run_ok && !stop_reg && !brake && v_up < 33'(vc_m)
      |=> vel_reg == $past(vel_reg) + 28'($past(acc_reg));
  endproperty
  a_ramp_up: assert property (p_ramp_up) // RL1
    else $error("speed did not rise by acceleration");

  property p_hold;
    run_ok && !stop_reg && !brake && vel_reg == vc_m
      |=> vel_reg == $past(vel_reg);
  endproperty
  a_hold: assert property (p_hold) // RL2
    else $error("speed not held at command");

  property p_brake;
    run_ok && !stop_reg && brake && vel_reg > VMIN_M &&
      vel_reg - VMIN_M > dec_reg
      |=> vel_reg == $past(vel_reg) - 28'($past(dec_reg));
  endproperty
  a_brake: assert property (p_brake) // RL3
    else $error("speed did not fall by deceleration");

  property p_bad;
    bad_rate |=> ($past(ADDR) == OFF_ACC ? acc_reg : dec_reg) == ACC_MIN
                 && ist_reg[E_BAD];
  endproperty
  a_bad: assert property (p_bad) // RL6
    else $error("bad ramp rate not clamped and flagged");

  property p_force_idle;
    st_reg == S_IDLE && force_ev && bl_en && !rev_tgl
      |=> st_reg == S_BL_OUT && goal_reg == $past(pos_reg - bld_reg);
  endproperty
  a_force_idle: assert property (p_force_idle) // RL11
    else $error("forced backlash did not start");

  property p_force_move;
    moving && !done && force_ev && bl_en && !rev_tgl
      |=> stop_reg && force_reg;
  endproperty
  a_force_move: assert property (p_force_move) // RL12
    else $error("forced backlash while moving did not stop");

  property p_flag;
    RD && ADDR == OFF_STAT |=> RDATA[1] == $past(bl_flag);
  endproperty
  a_flag: assert property (p_flag) // RL10
    else $error("backlash flag wrong in status");

  property p_rev;
    rev_tgl |=> pos_reg == -$past(pos_reg) && DIR == $past(DIR);
  endproperty
  a_rev: assert property (p_rev) // RL15
    else $error("reversal did not negate coordinate");

  property p_noramp;
    st_reg == S_IDLE && start_ev && !force_ev && !ramp_en && !rev_tgl
      |=> vel_reg == vsp_m;
  endproperty
  a_noramp: assert property (p_noramp) // RL18
    else $error("speed did not jump with ramp off");

  property p_reset;
    $fell(RESET) |-> ctrl_reg[C_RAMP];
  endproperty
  a_reset: assert property (p_reset) // RL17
    else $error("ramp not enabled after reset");
  c_bl_done: cover property (ev[E_BLD]);
  c_brake: cover property (run_ok && brake);
  c_forced: cover property (moving && force_ev && bl_en);
endmodule // tmp_top

// ===== tb/tmp_stage.sv
// Stage model: turns step pulses into a position and tracks its extremes
`timescale 1ns/100ps
module tmp_stage (
  input  wire logic               clk,  // Clock
  input  wire logic               rst,  // Synchronous reset
  input  wire logic               step, // Step pulse
  input  wire logic               dir,  // 1 = coordinate rises
  input  wire logic               clr,  // Restart extreme tracking
  output logic signed [31:0]      pos,  // Position in steps
  output logic signed [31:0]      lo,   // Lowest since clr
  output logic signed [31:0]      hi    // Highest since clr
);
  logic signed [31:0] nxt;
  assign nxt = dir ? pos + 32'sh1 : pos - 32'sh1;
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= '0;
      lo  <= '0;
      hi  <= '0;
    end else if (step) begin
      pos <= nxt;
      lo  <= (nxt < lo) ? nxt : lo;
      hi  <= (nxt > hi) ? nxt : hi;
    end else if (clr) begin
      lo <= pos;
      hi <= pos;
    end
  end
endmodule // tmp_stage

// ===== tb/tmp_top_tb.sv
// Self-checking bench for the motion profiler against a stage model
`timescale 1ns/100ps
module tmp_top_tb;
  import tmp_pkg::*;
  // Motion needs roughly 65k cycles; the rest is margin
  localparam int LIMIT = 90000;
  localparam logic [7:0] RA [6] = '{OFF_CTRL, OFF_ACC, OFF_DEC,
                                    OFF_SPD, OFF_BLS, OFF_BLD};
  localparam logic [31:0] RV [6] = '{32'(CTRL_RST), ACC_RST, DEC_RST,
                                     32'(SPD_RST), 32'(BLS_RST), BLD_RST};
  logic               CLK   = 1'b0;
  logic               RESET = 1'b1;
  logic [AW-1:0]      ADDR  = '0;
  logic [DW-1:0]      WDATA = '0;
  logic               WR    = 1'b0;
  logic               RD    = 1'b0;
  logic [DW-1:0]      RDATA;
  logic               STEP;
  logic               DIR;
  logic               IRQ;
  logic               clr   = 1'b0;
  logic signed [31:0] pos;
  logic signed [31:0] lo;
  logic signed [31:0] hi;
  logic signed [31:0] p0;
  logic [31:0]        d;
  logic [31:0]        rv;
  logic [31:0]        vmax;
  logic               flag_seen;
  int                 mismatches = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;

  always #5 CLK = ~CLK;

  tmp_top #(.TICK_CYC(100)) tmp_top_inst (.CLK(CLK), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .STEP(STEP), .DIR(DIR), .IRQ(IRQ));
  tmp_stage tmp_stage_inst (.clk(CLK), .rst(RESET), .step(STEP),
    .dir(DIR), .clr(clr), .pos(pos), .lo(lo), .hi(hi));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung move would otherwise poll for 30000 rounds before the bench moves on
  always @(posedge CLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask

  function automatic logic [31:0] clamp_rate(input logic [31:0] v);
    return (v < ACC_MIN) ? ACC_MIN : v;
  endfunction

  // Polls until motion ends, keeping peak speed and the backlash flag
  task automatic run_to_idle();
    logic [31:0] s;
    logic [31:0] v;
    vmax = '0;
    flag_seen = 1'b0;
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 30000; i++) begin
      rd(OFF_VEL, v);
      if (v > vmax) vmax = v;
      rd(OFF_STAT, s);
      if (s[1] === 1'b1) flag_seen = 1'b1;
      if (s[0] === 1'b0) break;
    end
  endtask

  task automatic go(input logic signed [31:0] t);
    @(posedge CLK);
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
    wr(OFF_TGT, t);
    run_to_idle();
    chk("stage position", t, pos);
    rd(OFF_POS, d);
    chk("position register", t, d);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    void'($urandom(25136));
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], d);
      chk("reset value", RV[i], d);
    end
    rd(8'hfc, d);
    chk("unmapped read", 32'h0, d);
    end_test("reset");

    wr(OFF_IMSK, 32'h2);
    rd(OFF_IST, d);
    for (int i = 0; i < 6; i++) begin
      rv = (i < 2) ? 32'(333 + i) : $urandom_range(400, 1);
      wr(i[0] ? OFF_DEC : OFF_ACC, rv);
      repeat (3) @(posedge CLK);
      #1 chk("interrupt", 32'(rv < ACC_MIN), 32'(IRQ));
      rd(i[0] ? OFF_DEC : OFF_ACC, d);
      chk("clamped rate", clamp_rate(rv), d);
      rd(OFF_IST, d);
      chk("bad value event", 32'(rv < ACC_MIN) << 1, d);
      repeat (3) @(posedge CLK);
      #1 chk("interrupt cleared", 32'h0, 32'(IRQ));
    end
    wr(OFF_IMSK, 32'h0);
    wr(OFF_ACC, 32'h5);
    repeat (3) @(posedge CLK);
    #1 chk("masked interrupt", 32'h0, 32'(IRQ));
    wr(OFF_ACC, 32'h05f5e100);
    wr(OFF_DEC, 32'h000f4240);
    rd(OFF_ACC, d);
    chk("acceleration", 32'h05f5e100, d);
    rd(OFF_DEC, d);
    chk("deceleration", 32'h000f4240, d);
    rd(OFF_IST, d);
    chk("sticky bad value", 32'h2, d);
    end_test("rates");

    wr(OFF_SPD, 32'h000186a0);
    wr(OFF_BLS, 32'h000186a0);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IMSK, 32'h1);
    go(32'sh5);
    chk("jump to speed", 32'h05f5e100, vmax);
    #1 chk("done interrupt", 32'h1, 32'(IRQ));
    rd(OFF_IST, d);
    chk("done event", 32'h1, d);
    for (int i = 0; i < 3; i++) begin
      p0 = pos;
      go($urandom_range(1) ? p0 + 32'sh2 : p0 - 32'sh3);
    end
    end_test("no ramp");

    wr(OFF_CTRL, 32'h1);
    wr(OFF_DEC, 32'h05f5e100);
    go(pos + 32'sh6);
    chk("cruise speed", 32'h05f5e100, vmax);
    wr(OFF_ACC, 32'h000f4240);
    wr(OFF_DEC, 32'h000f4240);
    go(pos + 32'sh4);
    chk("triangular peak", 32'h1, 32'(vmax < 32'h05f5e100));
    end_test("ramps");

    wr(OFF_CTRL, 32'h2);
    wr(OFF_BLD, 32'h3);
    p0 = pos;
    go(p0 - 32'sh4);
    chk("overshoot point", p0 - 32'sh7, lo);
    chk("backlash flag", 32'h1, 32'(flag_seen));
    go(p0);
    chk("no overshoot", p0, hi);
    chk("flag quiet", 32'h0, 32'(flag_seen));
    @(posedge CLK);
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
    wr(OFF_CMD, 32'h1);
    run_to_idle();
    chk("forced excursion", p0 - 32'sh3, lo);
    chk("forced return", p0, pos);
    chk("forced flag", 32'h1, 32'(flag_seen));
    wr(OFF_CTRL, 32'h3);
    wr(OFF_ACC, 32'h05f5e100);
    wr(OFF_DEC, 32'h05f5e100);
    wr(OFF_TGT, p0 + 32'sh14);
    repeat (3000) @(posedge CLK);
    wr(OFF_CMD, 32'h1);
    run_to_idle();
    chk("stopped short", 32'h1, 32'(pos < p0 + 32'sh14));
    rd(OFF_POS, d);
    chk("stop position", pos, d);
    rd(OFF_IST, d);
    p0 = pos;
    wr(OFF_TGT, p0 + 32'sh14);
    repeat (2000) @(posedge CLK);
    wr(OFF_CMD, 32'h2);
    run_to_idle();
    chk("smooth stop", 32'h1, 32'(pos > p0 && pos < p0 + 32'sh14));
    rd(OFF_POS, d);
    chk("smooth stop position", pos, d);
    rd(OFF_IST, d);
    chk("stop event", 32'h1, d);
    end_test("backlash");

    rv = $urandom();
    wr(OFF_LIML, rv);
    wr(OFF_LIMR, ~rv);
    rd(OFF_POS, d);
    p0 = d;
    wr(OFF_CTRL, 32'h4);
    rd(OFF_POS, d);
    chk("reversed position", -p0, d);
    rd(OFF_LIML, d);
    chk("limit kept", rv, d);
    rd(OFF_LIMR, d);
    chk("right limit kept", ~rv, d);
    end_test("reverse");
    close_out();
  end
endmodule // tmp_top_tb
